// file: logic/lcdo_consts.vh
`ifndef LCDO_CONSTS_VH
`define LCDO_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define LCDO_IDX_LINK_CTRL 8'hA1
`define LCDO_IDX_SCRAMBLE 8'hA5
`define LCDO_IDX_OCT_FRAME 8'hA6
`define LCDO_IDX_FRAMES_MF 8'hA7
`define LCDO_IDX_OVR_ENABLE 8'hB4
`define LCDO_IDX_OVR_WORD_HI 8'hB8
`define LCDO_IDX_OVR_WORD_LO 8'hB9
`define LCDO_IDX_DETECT_CTRL 8'hD6
`define LCDO_IDX_ALIGN_CTRL 8'hE0
`define LCDO_IDX_STATUS 8'hE1

// ****************************************************************
// Field positions
// ****************************************************************
`define LCDO_BIT_CTRL_F 0
`define LCDO_BIT_CTRL_K 1
`define LCDO_BIT_SCRAMBLE 7
`define LCDO_BIT_OVR_LANE2 6
`define LCDO_BIT_FAST_EN 0
`define LCDO_BIT_PWR_EN 5
`define LCDO_BIT_ALIGN_EN 0

// ****************************************************************
// Reset and fixed link values
// ****************************************************************
`define LCDO_RST_OCT_FRAME 8'h01
`define LCDO_RST_REG 8'h00
`define LCDO_K_TWO_OCTET 5'h08
`define LCDO_K_ONE_OCTET 5'h10
`define LCDO_RES_N 5'h0D
`define LCDO_RES_NP 5'h0F
`define LCDO_LAST_OCTET 4'hD
`define LCDO_DB_TOP 7'h50
`define LCDO_DB_SPAN 7'h0F

`endif

// file: logic/lcdo_fifo.v
`timescale 1ns/100ps
`default_nettype none

// Small FIFO whose output word and valid come straight from registers.
module lcdo_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire nrst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign inReady = (count_q != DEPTH[AW:0]);
  assign push = inValid && inReady;
  // The output register reloads whenever it is empty or being taken and a word is stored.
  assign pop = (count_q != {(AW+1){1'b0}}) && (!outValid || outReady);

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + {{(AW-1){1'b0}}, 1'b1};
        outData <= mem[rdPtr_q];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      if (push && !pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// file: logic/lcdo_top.v
// Contract
// - Override enable replaces lane-2 coder word with stored 10-bit word.
// - Fast-code enable puts a 4-bit coarse sample on detect.
// - Power-estimate enable puts a 4-bit averaged power on detect; here only while fast-code enable is off, as fast-code takes priority.
// - Power estimate is logarithmic, about one decibel per code step.
// - Three-bit field selects the number of samples averaged.
// - Averaging window spans one thousand to sixteen thousand samples.
// - Alignment sequence is off after reset until enabled.
// - Send fourteen configuration octets, layout set by octets-per-frame.
// - Octet 4 carries octets-per-frame minus one: 1 or 0.
// - Device identifier and bank identifier are zero.
// - Frames-per-multiframe defaults 8 or 16 unless overridden.
// - Scramble flag in octet 3 follows software scramble enable.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "lcdo_consts.vh"

module lcdo_top #(
  parameter AVG_BASE_LOG2 = 10,
  parameter FIFO_DEPTH = 4
) (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [13:0] sampleData,
  input wire sampleValid,
  input wire [9:0] lane2Coded,
  output reg [9:0] lane2Out,
  output reg [3:0] detectOut,
  output wire alignValid,
  input wire alignReady,
  output wire [7:0] alignOctet,
  output wire [3:0] alignIndex,
  output wire alignLane
);

  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_DONE = 2'b10;
  localparam FW = 13;

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg [1:0] linkCtrl_q;
  reg softScrambleEn_q;
  reg [7:0] octFrame_q;
  reg [4:0] framesMf_q;
  reg lane2OverrideEn_q;
  reg [3:0] wordHi_q;
  reg [5:0] wordLo_q;
  reg fastCodeDetectEn_q;
  reg powerEstimateEn_q;
  reg [2:0] powerAvgWindowSel_q;
  reg alignEn_q;
  reg [3:0] powerCode_q;
  reg [1:0] state_q;

  wire [9:0] lane2OverrideWord = {wordHi_q, wordLo_q};
  wire [9:0] regIdx = paddr[11:2];
  wire setupPhase = psel && !penable;
  wire wrDone = psel && penable && pready && pwrite;

  function known;
    input [9:0] idx;
    begin
      case (idx)
        {2'b00, `LCDO_IDX_LINK_CTRL}, {2'b00, `LCDO_IDX_SCRAMBLE},
        {2'b00, `LCDO_IDX_OCT_FRAME}, {2'b00, `LCDO_IDX_FRAMES_MF},
        {2'b00, `LCDO_IDX_OVR_ENABLE}, {2'b00, `LCDO_IDX_OVR_WORD_HI},
        {2'b00, `LCDO_IDX_OVR_WORD_LO}, {2'b00, `LCDO_IDX_DETECT_CTRL},
        {2'b00, `LCDO_IDX_ALIGN_CTRL}, {2'b00, `LCDO_IDX_STATUS}: begin
          known = 1'b1;
        end
        default: begin
          known = 1'b0;
        end
      endcase
    end
  endfunction

  reg [7:0] rdVal;
  always @* begin
    rdVal = 8'h00;
    case (regIdx)
      {2'b00, `LCDO_IDX_LINK_CTRL}: rdVal = {6'h00, linkCtrl_q};
      {2'b00, `LCDO_IDX_SCRAMBLE}: rdVal = {softScrambleEn_q, 7'h00};
      {2'b00, `LCDO_IDX_OCT_FRAME}: rdVal = octFrame_q;
      {2'b00, `LCDO_IDX_FRAMES_MF}: rdVal = {3'h0, framesMf_q};
      {2'b00, `LCDO_IDX_OVR_ENABLE}: rdVal = {1'b0, lane2OverrideEn_q, 6'h00};
      {2'b00, `LCDO_IDX_OVR_WORD_HI}: rdVal = {wordHi_q, 4'h0};
      {2'b00, `LCDO_IDX_OVR_WORD_LO}: rdVal = {wordLo_q, 2'h0};
      {2'b00, `LCDO_IDX_DETECT_CTRL}: begin
        rdVal = {2'h0, powerEstimateEn_q, powerAvgWindowSel_q, 1'b0,
          fastCodeDetectEn_q};
      end
      {2'b00, `LCDO_IDX_ALIGN_CTRL}: rdVal = {7'h00, alignEn_q};
      {2'b00, `LCDO_IDX_STATUS}: rdVal = {2'h0, state_q, powerCode_q};
      default: rdVal = 8'h00;
    endcase
  end

  // Answer is prepared in the setup cycle so that no wait state is added.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        prdata <= pwrite ? 32'h00000000 : {24'h000000, rdVal};
        pslverr <= !known(regIdx);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkCtrl_q <= 2'b00;
      softScrambleEn_q <= 1'b0;
      octFrame_q <= `LCDO_RST_OCT_FRAME;
      framesMf_q <= 5'h00;
      lane2OverrideEn_q <= 1'b0;
      wordHi_q <= 4'h0;
      wordLo_q <= 6'h00;
      fastCodeDetectEn_q <= 1'b0;
      powerEstimateEn_q <= 1'b0;
      powerAvgWindowSel_q <= 3'h0;
      alignEn_q <= 1'b0;
    end else if (wrDone) begin
      case (regIdx)
        {2'b00, `LCDO_IDX_LINK_CTRL}: linkCtrl_q <= pwdata[1:0];
        {2'b00, `LCDO_IDX_SCRAMBLE}: begin
          softScrambleEn_q <= pwdata[`LCDO_BIT_SCRAMBLE];
        end
        {2'b00, `LCDO_IDX_OCT_FRAME}: begin
          if (linkCtrl_q[`LCDO_BIT_CTRL_F]) begin
            octFrame_q <= pwdata[7:0];
          end
        end
        {2'b00, `LCDO_IDX_FRAMES_MF}: begin
          if (linkCtrl_q[`LCDO_BIT_CTRL_K]) begin
            framesMf_q <= pwdata[4:0];
          end
        end
        {2'b00, `LCDO_IDX_OVR_ENABLE}: begin
          lane2OverrideEn_q <= pwdata[`LCDO_BIT_OVR_LANE2];
        end
        {2'b00, `LCDO_IDX_OVR_WORD_HI}: wordHi_q <= pwdata[7:4];
        {2'b00, `LCDO_IDX_OVR_WORD_LO}: wordLo_q <= pwdata[7:2];
        {2'b00, `LCDO_IDX_DETECT_CTRL}: begin
          fastCodeDetectEn_q <= pwdata[`LCDO_BIT_FAST_EN];
          powerEstimateEn_q <= pwdata[`LCDO_BIT_PWR_EN];
          powerAvgWindowSel_q <= pwdata[4:2];
        end
        {2'b00, `LCDO_IDX_ALIGN_CTRL}: begin
          alignEn_q <= pwdata[`LCDO_BIT_ALIGN_EN];
        end
        default: begin
          alignEn_q <= alignEn_q;
        end
      endcase
    end
  end

  // ****************************************************************
  // Lane-2 override
  // ****************************************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane2Out <= 10'h000;
    end else begin
      lane2Out <= lane2OverrideEn_q ? lane2OverrideWord : lane2Coded;
    end
  end

  // ****************************************************************
  // Power estimate
  // ****************************************************************
  reg [14:0] sampleCnt_q;
  reg [40:0] powerAcc_q;
  wire [13:0] mag = sampleData[13] ? (~sampleData + 14'h0001) : sampleData;
  wire [27:0] square = mag * mag;
  // Codes above four saturate at the longest window.
  wire [2:0] winSel = (powerAvgWindowSel_q > 3'h4) ? 3'h4 :
    powerAvgWindowSel_q;
  wire [5:0] shiftAmt = AVG_BASE_LOG2[5:0] + {3'h0, winSel};
  wire [14:0] lastSample = (15'h0001 << shiftAmt) - 15'h0001;
  wire [40:0] accNext = powerAcc_q + {13'h0000, square};
  wire [40:0] meanWide = accNext >> shiftAmt;
  wire [26:0] mean = meanWide[26:0];

  // Three decibels per power-of-two and a coarse mantissa lookup.
  function [6:0] toDb;
    input [26:0] v;
    integer i;
    reg [4:0] pos;
    reg [1:0] man;
    begin
      pos = 5'h00;
      man = 2'b00;
      for (i = 1; i < 27; i = i + 1) begin
        if (v[i]) begin
          pos = i[4:0];
          man = (i > 1) ? {v[i-1], v[i-2]} : {v[0], 1'b0};
        end
      end
      toDb = {pos, 1'b0} + {2'b00, pos} +
        ((man == 2'b00) ? 7'h00 : (man == 2'b01) ? 7'h01 : 7'h02);
    end
  endfunction

  wire [6:0] dbVal = toDb(mean);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sampleCnt_q <= 15'h0000;
      powerAcc_q <= 41'h00000000000;
      powerCode_q <= 4'h0;
    end else if (sampleValid) begin
      if (sampleCnt_q >= lastSample) begin
        sampleCnt_q <= 15'h0000;
        powerAcc_q <= 41'h00000000000;
        if (dbVal <= `LCDO_DB_TOP - `LCDO_DB_SPAN) begin
          powerCode_q <= 4'h0;
        end else if (dbVal >= `LCDO_DB_TOP) begin
          powerCode_q <= 4'hF;
        end else begin
          powerCode_q <= dbVal[3:0] - 4'h1;
        end
      end else begin
        sampleCnt_q <= sampleCnt_q + 15'h0001;
        powerAcc_q <= accNext;
      end
    end
  end

  // ****************************************************************
  // Detect output
  // ****************************************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      detectOut <= 4'h0;
    end else if (fastCodeDetectEn_q) begin
      detectOut <= sampleData[13:10];
    end else if (powerEstimateEn_q) begin
      detectOut <= powerCode_q;
    end else begin
      detectOut <= 4'h0;
    end
  end

  // ****************************************************************
  // Alignment configuration octets
  // ****************************************************************
  wire twoLane = (octFrame_q == 8'h00);
  wire [4:0] framesMf = linkCtrl_q[`LCDO_BIT_CTRL_K] ? framesMf_q :
    (twoLane ? `LCDO_K_ONE_OCTET : `LCDO_K_TWO_OCTET);
  wire [4:0] lanesM1 = twoLane ? 5'h01 : 5'h00;
  wire [7:0] checksum = {7'h00, softScrambleEn_q} + {3'h0, lanesM1} +
    octFrame_q + {3'h0, framesMf} + {3'h0, `LCDO_RES_N} +
    {3'h0, `LCDO_RES_NP};

  function [7:0] octetOf;
    input [3:0] idx;
    input lid;
    begin
      case (idx)
        4'h2: octetOf = {7'h00, lid};
        4'h3: octetOf = {softScrambleEn_q, 2'b00, lanesM1};
        4'h4: octetOf = octFrame_q;
        4'h5: octetOf = {3'h0, framesMf};
        4'h7: octetOf = {3'h0, `LCDO_RES_N};
        4'h8: octetOf = {3'h0, `LCDO_RES_NP};
        4'hD: octetOf = checksum + {7'h00, lid};
        default: octetOf = 8'h00;
      endcase
    end
  endfunction

  reg [3:0] octIdx_q;
  reg lane_q;
  wire fifoInReady;
  wire pushOctet = (state_q == ST_RUN);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      octIdx_q <= 4'h0;
      lane_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (alignEn_q) begin
            state_q <= ST_RUN;
          end
          octIdx_q <= 4'h0;
          lane_q <= 1'b0;
        end
        ST_RUN: begin
          if (fifoInReady) begin
            if (octIdx_q != `LCDO_LAST_OCTET) begin
              octIdx_q <= octIdx_q + 4'h1;
            end else if (twoLane && !lane_q) begin
              octIdx_q <= 4'h0;
              lane_q <= 1'b1;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // Clearing the enable re-arms one more sequence.
          if (!alignEn_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  wire [FW-1:0] fifoOut;

  lcdo_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(pushOctet),
    .inReady(fifoInReady),
    .inData({lane_q, octIdx_q, octetOf(octIdx_q, lane_q)}),
    .outValid(alignValid),
    .outReady(alignReady),
    .outData(fifoOut)
  );

  assign alignLane = fifoOut[12];
  assign alignIndex = fifoOut[11:8];
  assign alignOctet = fifoOut[7:0];

endmodule

`default_nettype wire

// file: dv/lcdo_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdo_consts.vh"
module lcdo_chk (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire sampleValid,
  input wire [13:0] sampleData,
  input wire [9:0] lane2Coded,
  input wire [9:0] lane2Out,
  input wire [3:0] detectOut,
  input wire alignValid,
  input wire alignReady,
  input wire [7:0] alignOctet,
  input wire [3:0] alignIndex,
  input wire alignLane
);
  // ****************************************************
  // Shadow of the control bits, rebuilt from bus writes
  // ****************************************************
  reg [7:0] det_q, hi_q, lo_q;
  reg ovr_q, aln_q, ok_q;
  wire wr = psel & penable & pready & pwrite & ~pslverr;
  wire [9:0] ix = paddr[11:2];
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      det_q <= 8'h00;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      ovr_q <= 1'b0;
      aln_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      ok_q <= 1'b1;
      if (wr && ix == `LCDO_IDX_DETECT_CTRL) det_q <= pwdata[7:0];
      if (wr && ix == `LCDO_IDX_OVR_WORD_HI) hi_q <= pwdata[7:0];
      if (wr && ix == `LCDO_IDX_OVR_WORD_LO) lo_q <= pwdata[7:0];
      if (wr && ix == `LCDO_IDX_OVR_ENABLE) ovr_q <= pwdata[6];
      if (wr && ix == `LCDO_IDX_ALIGN_CTRL && pwdata[0]) aln_q <= 1'b1;
    end
  end
  // ****************************************************
  // Properties
  // ****************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_ovr; ovr_q && $stable(ovr_q) && $stable({hi_q, lo_q})
    |-> lane2Out == {hi_q[7:4], lo_q[7:2]}; endproperty
  a_ovr: assert property (p_ovr) else $error("override word");
  property p_pass; ok_q && !ovr_q && $stable(ovr_q)
    |-> lane2Out == $past(lane2Coded); endproperty
  a_pass: assert property (p_pass) else $error("coder word");
  property p_fast; ok_q && det_q[0] && $stable(det_q)
    |-> detectOut == $past(sampleData[13:10]); endproperty
  a_fast: assert property (p_fast) else $error("fast code");
  // The run of eight idle cycles leaves room for the estimate pipeline.
  property p_pwr; (det_q[5] && !det_q[0] && !sampleValid
    && $stable(det_q)) [*8] |=> $stable(detectOut); endproperty
  a_pwr: assert property (p_pwr) else $error("estimate moved");
  property p_off; !aln_q |-> !alignValid; endproperty
  a_off: assert property (p_off) else $error("early align");
  property p_idx; alignValid |-> alignIndex <= 4'hD; endproperty
  a_idx: assert property (p_idx) else $error("octet number");
  property p_hold; alignValid && !alignReady |=> alignValid
    && $stable({alignOctet, alignIndex, alignLane}); endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_ids; alignValid && alignIndex <= 4'h1 |-> alignOctet[3:0]
    == 4'h0 && (alignIndex == 4'h1 || alignOctet == 8'h00); endproperty
  a_ids: assert property (p_ids) else $error("id octet");
  property p_lid; alignValid && alignIndex == 4'h2
    |-> alignOctet[4:0] == {4'h0, alignLane}; endproperty
  a_lid: assert property (p_lid) else $error("lane id");
  property p_oct4; alignValid && alignLane && alignIndex == 4'h4
    |-> alignOctet == 8'h00; endproperty
  a_oct4: assert property (p_oct4) else $error("octet 4");
  property p_fix; alignValid && (alignIndex == 4'h7 || alignIndex == 4'h8)
    |-> alignOctet[4:0] == (alignIndex == 4'h7 ? 5'h0D : 5'h0F); endproperty
  a_fix: assert property (p_fix) else $error("resolution");
  c_ovr: cover property (ovr_q && lane2Out == {hi_q[7:4], lo_q[7:2]});
  c_two: cover property (alignValid && alignLane && alignIndex == 4'hD);
  c_pwr: cover property (det_q[5] && detectOut == 4'h7);
endmodule
bind lcdo_top lcdo_chk chk_u (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid),
  .sampleData(sampleData), .lane2Coded(lane2Coded), .lane2Out(lane2Out),
  .detectOut(detectOut), .alignValid(alignValid), .alignReady(alignReady),
  .alignOctet(alignOctet), .alignIndex(alignIndex), .alignLane(alignLane));
`default_nettype wire

// file: dv/lcdo_sink.sv
`timescale 1ns/100ps
`default_nettype none
// A receiver that drops ready one cycle in three and fully while stalled.
module lcdo_sink (
  input wire clk,
  input wire nrst,
  input wire alignValid,
  input wire [7:0] alignOctet,
  input wire [3:0] alignIndex,
  input wire alignLane,
  input wire stall,
  output reg alignReady
);
  reg [12:0] got [0:63];
  reg [1:0] ph_q;
  integer cnt;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alignReady <= 1'b0;
      ph_q <= 2'd0;
      cnt <= 0;
    end else begin
      ph_q <= (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
      alignReady <= !stall && ph_q != 2'd2;
      if (alignValid && alignReady && cnt < 64) begin
        got[cnt] <= {alignLane, alignIndex, alignOctet};
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/lcdo_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdo_consts.vh"
module lcdo_top_tb;
  reg clk, nrst, psel, penable, pwrite, sampleValid, stall, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [13:0] sampleData;
  reg [9:0] lane2Coded;
  wire [31:0] prdata;
  wire pready, pslverr, alignValid, alignReady, alignLane;
  wire [9:0] lane2Out;
  wire [3:0] detectOut, alignIndex;
  wire [7:0] alignOctet;
  integer n_errors, n_compared, i, s;
  integer cyc = 0;
  localparam [14:0] SEL = {3'd2, 3'd7, 3'd0, 3'd1, 3'd0};
  localparam [69:0] SMP = {14'h11E4, 14'h0000, 14'h0800, 14'h3000,
    14'h1000};
  localparam [19:0] CODE = {4'h8, 4'h0, 4'h1, 4'h7, 4'h7};
  lcdo_top #(.AVG_BASE_LOG2(2), .FIFO_DEPTH(4)) dut_u (.clk(clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleData(sampleData), .sampleValid(sampleValid),
    .lane2Coded(lane2Coded), .lane2Out(lane2Out), .detectOut(detectOut),
    .alignValid(alignValid), .alignReady(alignReady),
    .alignOctet(alignOctet), .alignIndex(alignIndex), .alignLane(alignLane));
  lcdo_sink sink_u (.clk(clk), .nrst(nrst), .alignValid(alignValid),
    .alignOctet(alignOctet), .alignIndex(alignIndex),
    .alignLane(alignLane), .stall(stall), .alignReady(alignReady));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************************************************
  // Tasks
  // ****************************************************
  task finish_test;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [9:0] ix, input [7:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      if (pready !== 1'b1) begin
        chk(32'h0, 32'h1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [9:0] ix, input [31:0] exp, input eErr);
    begin
      apb(1'b0, ix, 8'h00);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, eErr});
    end
  endtask
  task waitCnt(input integer target);
    integer n;
    begin
      n = 0;
      while (sink_u.cnt < target && n < 2000) begin
        n = n + 1;
        @(posedge clk);
      end
      chk(sink_u.cnt >= target, 1'b1);
    end
  endtask
  function [12:0] expW(input [3:0] ix, input lane, two, scr,
    input [4:0] k);
    reg [7:0] o, sum;
    begin
      sum = scr + two + !two + k + 8'h0D + 8'h0F + lane;
      case (ix)
        4'h2: o = {7'h0, lane};
        4'h3: o = {scr, 6'h0, two};
        4'h4: o = {7'h0, !two};
        4'h5: o = {3'h0, k};
        4'h7: o = 8'h0D;
        4'h8: o = 8'h0F;
        4'hD: o = sum;
        default: o = 8'h00;
      endcase
      expW = {lane, ix, o};
    end
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lane2Coded <= nrst ? lane2Coded + 10'h003 : 10'h000;
    if (cyc == 8000) begin
      n_errors = n_errors + 1;
      finish_test;
    end
  end
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    {nrst, psel, penable, pwrite, sampleValid, err} = 6'h00;
    {paddr, pwdata, rd, sampleData} = 90'h0;
    stall = 1'b1;
    n_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    sampleValid <= 1'b1;
    rdc(`LCDO_IDX_OCT_FRAME, 32'h01, 1'b0);
    rdc(`LCDO_IDX_DETECT_CTRL, 32'h00, 1'b0);
    rdc(10'h3FF, 32'h00, 1'b1);
    chk(alignValid, 1'b0);
    apb(1'b1, `LCDO_IDX_OVR_WORD_HI, 8'hA0);
    apb(1'b1, `LCDO_IDX_OVR_WORD_LO, 8'hB4);
    apb(1'b1, `LCDO_IDX_OVR_ENABLE, 8'h40);
    repeat (3) @(posedge clk);
    chk(lane2Out, 10'h2AD);
    apb(1'b1, `LCDO_IDX_OVR_ENABLE, 8'h00);
    apb(1'b1, `LCDO_IDX_DETECT_CTRL, 8'h01);
    sampleData <= 14'h2ABC;
    repeat (3) @(posedge clk);
    chk(detectOut, 4'hA);
    for (i = 0; i < 5; i = i + 1) begin
      s = (SEL[i*3 +: 3] > 4) ? 4 : SEL[i*3 +: 3];
      apb(1'b1, `LCDO_IDX_DETECT_CTRL, {3'b001, SEL[i*3 +: 3], 2'b00});
      sampleData <= SMP[i*14 +: 14];
      repeat ((12 << s) + 20) @(posedge clk);
      chk(detectOut, CODE[i*4 +: 4]);
    end
    sampleValid <= 1'b0;
    repeat (12) @(posedge clk);
    sampleValid <= 1'b1;
    // One large sample in eight: an eight-sample window always sees one.
    apb(1'b1, `LCDO_IDX_DETECT_CTRL, 8'h24);
    for (s = 0; s < 96; s = s + 1) begin
      sampleData <= (s % 8 == 0) ? 14'h2000 : 14'h0000;
      @(posedge clk);
    end
    chk(detectOut, 4'h4);
    apb(1'b1, `LCDO_IDX_DETECT_CTRL, 8'h21);
    sampleData <= 14'h1555;
    repeat (3) @(posedge clk);
    chk(detectOut, 4'h5);
    apb(1'b1, `LCDO_IDX_SCRAMBLE, 8'h80);
    apb(1'b1, `LCDO_IDX_ALIGN_CTRL, 8'h01);
    repeat (30) @(posedge clk);
    chk(alignValid, 1'b1);
    stall <= 1'b0;
    waitCnt(14);
    for (i = 0; i < 14; i = i + 1) begin
      chk(sink_u.got[i], expW(i, 1'b0, 1'b0, 1'b1, 5'h08));
    end
    repeat (10) @(posedge clk);
    chk(alignValid, 1'b0);
    apb(1'b1, `LCDO_IDX_LINK_CTRL, 8'h01);
    apb(1'b1, `LCDO_IDX_OCT_FRAME, 8'h00);
    apb(1'b1, `LCDO_IDX_FRAMES_MF, 8'h05);
    rdc(`LCDO_IDX_FRAMES_MF, 32'h00, 1'b0);
    apb(1'b1, `LCDO_IDX_SCRAMBLE, 8'h00);
    apb(1'b1, `LCDO_IDX_ALIGN_CTRL, 8'h00);
    apb(1'b1, `LCDO_IDX_ALIGN_CTRL, 8'h01);
    waitCnt(42);
    for (i = 0; i < 28; i = i + 1) begin
      chk(sink_u.got[14+i], expW(i % 14, i >= 14, 1'b1, 1'b0, 5'h10));
    end
    apb(1'b1, `LCDO_IDX_LINK_CTRL, 8'h03);
    apb(1'b1, `LCDO_IDX_FRAMES_MF, 8'h05);
    rdc(`LCDO_IDX_FRAMES_MF, 32'h05, 1'b0);
    finish_test;
  end
endmodule
`default_nettype wire
